// File: cag_addr_gen.sv
// address generator for branch targets and data operands
`timescale 1ns/1ns
`default_nettype none
// Operation
// - table call: 5-bit field picks a word in 0080H-00BFH, word loads the PC
// - table call targets stay in 00000H-0FFFFH, upper PC bits zero
// - register branch loads PC with code segment over the selected pair
// - register branch only for call via any pair or branch via first pair
// - implied operands only for the unsigned multiply instruction
// - 3-bit field picks one of eight bytes, 2-bit field one of four pairs
// - unprefixed 16-bit direct address lands in F0000H-FFFFFH
// - extra segment prefix supplies the upper four address bits
// - short direct uses 8 bits to reach only FFE20H-FFF1FH
// - word short direct reaches only even addresses
// - special register addressing uses 8 bits to reach FFF00H-FFFFFH
// - word special register access reaches only even addresses
// - indirect uses third or fourth pair, fixed top or segment area
// - based adds a pair or immediate base to a byte or word offset
// - based forms: third, fourth, stack plus byte; word plus B, C or pair
// - based indexed adds fourth pair and byte B or C
module cag_addr_gen (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic reqValid,
	input wire cag_pkg::cag_req_type req,
	input wire cag_pkg::cag_regs_type regs,
	input wire logic tblRdValid,
	input wire logic [15:0] tblRdData,
	output logic reqReady,
	output logic dataValid,
	output logic [19:0] dataAddr,
	output logic wordAccess,
	output logic regValid,
	output logic [15:0] regValue,
	output logic pcLoad,
	output logic [19:0] pcValue,
	output logic tblReq,
	output logic [19:0] tblAddr,
	output logic addrError
);
	import cag_pkg::*;

	cag_state_type state;
	cag_state_type next_state;
	cag_mode_type outMode;
	logic taken;
	logic [7:0] selReg8;
	logic [15:0] selPair;
	logic [15:0] pairFirst;
	logic [15:0] pairSecond;
	logic [15:0] pairThird;
	logic [15:0] pairFourth;
	logic [7:0] byteB;
	logic [7:0] byteC;
	logic [7:0] offByte;
	logic [15:0] next_low;
	logic [3:0] next_upper;
	logic next_data;
	logic next_reg;
	logic [15:0] next_regValue;
	logic next_pc;
	logic [19:0] next_pcValue;
	logic next_tbl;
	logic next_err;

	cag_operand_sel u_sel (
		.regs(regs),
		.regSel(req.regSel),
		.pairSel(req.pairSel),
		.reg8(selReg8),
		.pair16(selPair)
	);

	// fixed pairs and bytes used by the branch, implied and based forms
	always_comb begin
		pairFirst = {regs.gpr[REG_A], regs.gpr[REG_X]};
		pairSecond = {regs.gpr[REG_B], regs.gpr[REG_C]};
		pairThird = {regs.gpr[3'h5], regs.gpr[3'h4]};
		pairFourth = {regs.gpr[3'h7], regs.gpr[3'h6]};
		byteB = regs.gpr[REG_B];
		byteC = regs.gpr[REG_C];
		offByte = req.offsetB ? byteB : byteC;
	end

	assign taken = reqValid && (state == ST_IDLE);

	// per-mode address, operand and branch target
	always_comb begin
		next_low = 16'h0000;
		next_upper = cag_upper(req.esPrefix, regs.es);
		next_data = 1'b0;
		next_reg = 1'b0;
		next_regValue = 16'h0000;
		next_pc = 1'b0;
		next_pcValue = 20'h00000;
		next_tbl = 1'b0;
		next_err = 1'b0;
		case (req.mode)
			MODE_TBL_CALL: next_tbl = 1'b1;
			MODE_REG_CALL: begin
				next_pc = 1'b1;
				next_pcValue = {regs.cs, selPair};
			end
			MODE_REG_BR: begin
				// only the first pair may serve a plain branch
				if (req.pairSel == PAIR_FIRST) begin
					next_pc = 1'b1;
					next_pcValue = {regs.cs, pairFirst};
				end else begin
					next_err = 1'b1;
				end
			end
			MODE_IMPLIED_MUL: begin
				next_reg = 1'b1;
				next_regValue = pairFirst;
			end
			MODE_REG8: begin
				next_reg = 1'b1;
				next_regValue = {8'h00, selReg8};
			end
			MODE_REG16: begin
				next_reg = 1'b1;
				next_regValue = selPair;
			end
			MODE_DIRECT: begin
				next_data = 1'b1;
				next_low = req.imm16;
			end
			MODE_SHORT: begin
				next_upper = SHORT_LOW_BASE[19:16];
				if (req.imm8 >= SHORT_SPLIT) begin
					next_low = 16'(SHORT_LOW_BASE[15:0] + {8'h00, req.imm8});
				end else begin
					next_low = 16'(SHORT_HIGH_BASE[15:0] + {8'h00, req.imm8});
				end
				if (req.wordOp && req.imm8[0]) begin
					next_err = 1'b1;
				end else begin
					next_data = 1'b1;
				end
			end
			MODE_SFR: begin
				next_upper = SFR_BASE[19:16];
				next_low = 16'(SFR_BASE[15:0] + {8'h00, req.imm8});
				if (req.wordOp && req.imm8[0]) begin
					next_err = 1'b1;
				end else begin
					next_data = 1'b1;
				end
			end
			MODE_REG_IND: begin
				next_low = selPair;
				if (req.pairSel == PAIR_THIRD || req.pairSel == PAIR_FOURTH) begin
					next_data = 1'b1;
				end else begin
					next_err = 1'b1;
				end
			end
			MODE_BASED_RP: begin
				next_low = cag_add16(selPair, {8'h00, req.imm8});
				if (req.pairSel == PAIR_THIRD || req.pairSel == PAIR_FOURTH) begin
					next_data = 1'b1;
				end else begin
					next_err = 1'b1;
				end
			end
			MODE_BASED_SP: begin
				next_low = cag_add16(regs.sp, {8'h00, req.imm8});
				// the stack form has no prefixed variant
				if (req.esPrefix) begin
					next_err = 1'b1;
				end else begin
					next_data = 1'b1;
				end
			end
			MODE_BASED_WBYTE: begin
				next_data = 1'b1;
				next_low = cag_add16(req.imm16, {8'h00, offByte});
			end
			MODE_BASED_WPAIR: begin
				next_data = 1'b1;
				next_low = cag_add16(req.imm16, pairSecond);
			end
			MODE_BASED_IDX: begin
				next_data = 1'b1;
				next_low = cag_add16(pairFourth, {8'h00, offByte});
			end
			default: next_err = 1'b1;
		endcase
	end

	// sequencing: a table call waits for its table word
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (taken && next_tbl) begin
					next_state = ST_TBL;
				end
			end
			ST_TBL: begin
				if (tblRdValid) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// state and ready
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
			reqReady <= 1'b0;
		end else begin
			state <= next_state;
			reqReady <= (next_state == ST_IDLE);
		end
	end

	// data address result
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			dataValid <= 1'b0;
			dataAddr <= 20'h00000;
			wordAccess <= 1'b0;
			outMode <= MODE_NONE;
		end else begin
			dataValid <= taken && next_data;
			wordAccess <= taken && next_data && req.wordOp;
			if (taken) begin
				dataAddr <= {next_upper, next_low};
				outMode <= req.mode;
			end
		end
	end

	// register operand result
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			regValid <= 1'b0;
			regValue <= 16'h0000;
		end else begin
			regValid <= taken && next_reg;
			if (taken && next_reg) begin
				regValue <= next_regValue;
			end
		end
	end

	// table word fetch request
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tblReq <= 1'b0;
			tblAddr <= 20'h00000;
		end else begin
			tblReq <= taken && next_tbl;
			if (taken && next_tbl) begin
				tblAddr <= cag_tbl_addr(req.imm8[4:0]);
			end
		end
	end

	// program counter load
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pcLoad <= 1'b0;
			pcValue <= 20'h00000;
		end else if (state == ST_TBL) begin
			pcLoad <= tblRdValid;
			if (tblRdValid) begin
				pcValue <= {SEG_LOW, tblRdData};
			end
		end else begin
			pcLoad <= taken && next_pc;
			if (taken && next_pc) begin
				pcValue <= next_pcValue;
			end
		end
	end

	// refused combinations
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			addrError <= 1'b0;
		end else begin
			addrError <= taken && next_err;
		end
	end

	// request of a given mode taken while idle, and table word arrival
	sequence s_taken(cag_mode_type m);
		reqValid && state == ST_IDLE && req.mode == m;
	endsequence
	sequence s_tblDone;
		state == ST_TBL && tblRdValid;
	endsequence
	property p_tblRange;
		@(posedge ref_clk) disable iff (!nrst)
		tblReq |-> (tblAddr >= TBL_BASE && tblAddr <= TBL_LAST && !tblAddr[0]);
	endproperty
	a_tblRange: assert property (p_tblRange) else $error("table address out of range");
	property p_tblStart;
		@(posedge ref_clk) disable iff (!nrst)
		s_taken(MODE_TBL_CALL) |=> tblReq && !pcLoad && state == ST_TBL;
	endproperty
	a_tblStart: assert property (p_tblStart) else $error("table call did not start");
	property p_tblTop;
		@(posedge ref_clk) disable iff (!nrst)
		s_tblDone |=> pcLoad && pcValue[19:16] == SEG_LOW && pcValue[15:0] == $past(tblRdData);
	endproperty
	a_tblTop: assert property (p_tblTop) else $error("table target outside low 64K");
	property p_regCall;
		@(posedge ref_clk) disable iff (!nrst)
		s_taken(MODE_REG_CALL) |=> pcLoad && pcValue == {$past(regs.cs), $past(selPair)};
	endproperty
	a_regCall: assert property (p_regCall) else $error("register call target wrong");
	property p_regBr;
		@(posedge ref_clk) disable iff (!nrst)
		s_taken(MODE_REG_BR) ##0 (req.pairSel != PAIR_FIRST) |=> addrError && !pcLoad;
	endproperty
	a_regBr: assert property (p_regBr) else $error("branch via other pair accepted");
	property p_implied;
		@(posedge ref_clk) disable iff (!nrst)
		s_taken(MODE_IMPLIED_MUL) |=> regValid && regValue == $past(pairFirst) && !dataValid;
	endproperty
	a_implied: assert property (p_implied) else $error("implied operands wrong");
	property p_direct;
		@(posedge ref_clk) disable iff (!nrst)
		s_taken(MODE_DIRECT) ##0 !req.esPrefix |=> dataValid && dataAddr == {SEG_TOP, $past(req.imm16)};
	endproperty
	a_direct: assert property (p_direct) else $error("direct address not in top area");
	property p_prefix;
		@(posedge ref_clk) disable iff (!nrst)
		reqValid && state == ST_IDLE && req.esPrefix && (req.mode == MODE_DIRECT
			|| req.mode == MODE_BASED_IDX || req.mode == MODE_BASED_WPAIR)
			|=> dataValid && dataAddr[19:16] == $past(regs.es);
	endproperty
	a_prefix: assert property (p_prefix) else $error("segment prefix ignored");
	property p_shortRange;
		@(posedge ref_clk) disable iff (!nrst)
		dataValid && outMode == MODE_SHORT |-> dataAddr >= SHORT_FIRST && dataAddr <= SHORT_LAST;
	endproperty
	a_shortRange: assert property (p_shortRange) else $error("short direct out of range");
	property p_shortOdd;
		@(posedge ref_clk) disable iff (!nrst)
		s_taken(MODE_SHORT) ##0 (req.wordOp && req.imm8[0]) |=> addrError && !dataValid;
	endproperty
	a_shortOdd: assert property (p_shortOdd) else $error("odd word short access accepted");
	property p_sfrRange;
		@(posedge ref_clk) disable iff (!nrst)
		dataValid && outMode == MODE_SFR |-> dataAddr >= SFR_BASE && dataAddr <= SFR_LAST
			&& !(wordAccess && dataAddr[0]);
	endproperty
	a_sfrRange: assert property (p_sfrRange) else $error("special register access out of range");
	property p_basedIdx;
		@(posedge ref_clk) disable iff (!nrst)
		s_taken(MODE_BASED_IDX) |=> dataValid
			&& dataAddr[15:0] == 16'($past(pairFourth) + {8'h00, $past(offByte)});
	endproperty
	a_basedIdx: assert property (p_basedIdx) else $error("based indexed sum wrong");
	property p_spPrefix;
		@(posedge ref_clk) disable iff (!nrst)
		s_taken(MODE_BASED_SP) ##0 req.esPrefix |=> addrError && !dataValid;
	endproperty
	a_spPrefix: assert property (p_spPrefix) else $error("prefixed stack form accepted");
endmodule
`default_nettype wire

// File: cag_pkg.sv
// constants, carrier types and shared address functions for the address generator
package cag_pkg;

	// address space and segment values
	localparam int ADDR_W = 20;
	localparam logic [3:0] SEG_TOP = 4'hF;
	localparam logic [3:0] SEG_LOW = 4'h0;

	// table call region
	localparam logic [19:0] TBL_BASE = 20'h00080;
	localparam logic [19:0] TBL_LAST = 20'h000BF;

	// short direct and special register regions
	localparam logic [7:0] SHORT_SPLIT = 8'h20;
	localparam logic [19:0] SHORT_LOW_BASE = 20'hFFE00;
	localparam logic [19:0] SHORT_HIGH_BASE = 20'hFFF00;
	localparam logic [19:0] SHORT_FIRST = 20'hFFE20;
	localparam logic [19:0] SHORT_LAST = 20'hFFF1F;
	localparam logic [19:0] SFR_BASE = 20'hFFF00;
	localparam logic [19:0] SFR_LAST = 20'hFFFFF;

	// register pair and byte register indices
	localparam logic [1:0] PAIR_FIRST = 2'h0;
	localparam logic [1:0] PAIR_SECOND = 2'h1;
	localparam logic [1:0] PAIR_THIRD = 2'h2;
	localparam logic [1:0] PAIR_FOURTH = 2'h3;
	localparam logic [2:0] REG_X = 3'h0;
	localparam logic [2:0] REG_A = 3'h1;
	localparam logic [2:0] REG_C = 3'h2;
	localparam logic [2:0] REG_B = 3'h3;

	// addressing modes presented by the decoder
	typedef enum logic [3:0] {
		MODE_TBL_CALL = 4'h0,
		MODE_REG_CALL = 4'h1,
		MODE_REG_BR = 4'h2,
		MODE_IMPLIED_MUL = 4'h3,
		MODE_REG8 = 4'h4,
		MODE_REG16 = 4'h5,
		MODE_DIRECT = 4'h6,
		MODE_SHORT = 4'h7,
		MODE_SFR = 4'h8,
		MODE_REG_IND = 4'h9,
		MODE_BASED_RP = 4'hA,
		MODE_BASED_SP = 4'hB,
		MODE_BASED_WBYTE = 4'hC,
		MODE_BASED_WPAIR = 4'hD,
		MODE_BASED_IDX = 4'hE,
		MODE_NONE = 4'hF
	} cag_mode_type;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_TBL = 1'b1
	} cag_state_type;

	// one decoded request
	typedef struct packed {
		cag_mode_type mode;
		logic [2:0] regSel;
		logic [1:0] pairSel;
		logic [7:0] imm8;
		logic [15:0] imm16;
		logic esPrefix;
		logic wordOp;
		logic offsetB;
	} cag_req_type;

	// current bank, stack pointer and segment registers
	typedef struct packed {
		logic [7:0][7:0] gpr;
		logic [15:0] sp;
		logic [3:0] cs;
		logic [3:0] es;
	} cag_regs_type;

	// upper address nibble: extra segment when prefixed, else all ones
	function automatic logic [3:0] cag_upper(input logic prefix, input logic [3:0] es);
		cag_upper = prefix ? es : SEG_TOP;
	endfunction

	// sums wrap inside the 64 K area
	function automatic logic [15:0] cag_add16(input logic [15:0] a, input logic [15:0] b);
		cag_add16 = 16'(a + b);
	endfunction

	// word entry of the table call region
	function automatic logic [19:0] cag_tbl_addr(input logic [4:0] idx);
		cag_tbl_addr = 20'(TBL_BASE + {idx, 1'b0});
	endfunction

endpackage

// File: cag_operand_sel.sv
// byte register and register pair selection from the current bank
`timescale 1ns/1ns
`default_nettype none
module cag_operand_sel (
	input wire cag_pkg::cag_regs_type regs,
	input wire logic [2:0] regSel,
	input wire logic [1:0] pairSel,
	output logic [7:0] reg8,
	output logic [15:0] pair16
);
	import cag_pkg::*;

	// three bit field picks a byte, two bit field a pair
	always_comb begin
		reg8 = regs.gpr[regSel];
		pair16 = {regs.gpr[{pairSel, 1'b1}], regs.gpr[{pairSel, 1'b0}]};
	end
endmodule
`default_nettype wire

// File: cag_addr_gen_tb.sv
// self-checking testbench for the address generator
`timescale 1ns/1ns
`default_nettype none
module cag_addr_gen_tb;
	import cag_pkg::*;
	logic ref_clk;
	logic nrst;
	logic reqValid;
	cag_req_type req;
	cag_regs_type regs;
	logic tblRdValid;
	logic [15:0] tblRdData;
	logic reqReady, dataValid, wordAccess, regValid, pcLoad, tblReq, addrError;
	logic [19:0] dataAddr, pcValue, tblAddr;
	logic [15:0] regValue;
	int n_errors;
	int n_compared;
	logic [23:0] expQ[$];
	logic [7:0] edges[4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
	cag_req_type r;

	cag_addr_gen u_cag_addr_gen (.ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid), .req(req),
		.regs(regs), .tblRdValid(tblRdValid), .tblRdData(tblRdData), .reqReady(reqReady),
		.dataValid(dataValid), .dataAddr(dataAddr), .wordAccess(wordAccess),
		.regValid(regValid), .regValue(regValue), .pcLoad(pcLoad), .pcValue(pcValue),
		.tblReq(tblReq), .tblAddr(tblAddr), .addrError(addrError));

	// free-running core clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// pair n is the odd byte over the even byte
	function automatic logic [15:0] pairOf(input cag_regs_type g, input logic [1:0] n);
		pairOf = {g.gpr[{n, 1'b1}], g.gpr[{n, 1'b0}]};
	endfunction

	// expected answer: kind, word flag, value
	function automatic logic [23:0] expOf(input cag_req_type q, input cag_regs_type g);
		logic [3:0] up;
		logic [7:0] bc;
		logic [23:0] err;
		up = q.esPrefix ? g.es : 4'hF;
		bc = q.offsetB ? g.gpr[3] : g.gpr[2];
		err = {3'h4, 21'h0};
		case (q.mode)
			MODE_TBL_CALL: expOf = {4'h6, 20'h00080 + {14'h0, q.imm8[4:0], 1'b0}};
			MODE_REG_CALL: expOf = {4'h4, g.cs, pairOf(g, q.pairSel)};
			MODE_REG_BR: expOf = (q.pairSel == 2'h0) ? {4'h4, g.cs, pairOf(g, 2'h0)} : err;
			MODE_IMPLIED_MUL: expOf = {4'h2, 4'h0, pairOf(g, 2'h0)};
			MODE_REG8: expOf = {4'h2, 12'h0, g.gpr[q.regSel]};
			MODE_REG16: expOf = {4'h2, 4'h0, pairOf(g, q.pairSel)};
			MODE_DIRECT: expOf = {3'h0, q.wordOp, up, q.imm16};
			MODE_SHORT: expOf = (q.wordOp && q.imm8[0]) ? err : {3'h0, q.wordOp,
				(q.imm8 >= 8'h20 ? 20'hFFE00 : 20'hFFF00) + {12'h0, q.imm8}};
			MODE_SFR: expOf = (q.wordOp && q.imm8[0]) ? err :
				{3'h0, q.wordOp, 20'hFFF00 + {12'h0, q.imm8}};
			MODE_REG_IND: expOf = q.pairSel[1] ? {3'h0, q.wordOp, up, pairOf(g, q.pairSel)} : err;
			MODE_BASED_RP: expOf = q.pairSel[1] ? {3'h0, q.wordOp, up,
				pairOf(g, q.pairSel) + {8'h0, q.imm8}} : err;
			MODE_BASED_SP: expOf = q.esPrefix ? err : {3'h0, q.wordOp, 4'hF, g.sp + {8'h0, q.imm8}};
			MODE_BASED_WBYTE: expOf = {3'h0, q.wordOp, up, q.imm16 + {8'h0, bc}};
			MODE_BASED_WPAIR: expOf = {3'h0, q.wordOp, up, q.imm16 + pairOf(g, 2'h1)};
			MODE_BASED_IDX: expOf = {3'h0, q.wordOp, up, pairOf(g, 2'h3) + {8'h0, bc}};
			default: expOf = err;
		endcase
	endfunction

	task check(input logic [23:0] seen, input logic [23:0] expected);
		n_compared++;
		if (seen !== expected) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask

	// compare one answer with the oldest note
	task take(input logic [23:0] seen);
		logic [23:0] e;
		e = 'x;
		if (expQ.size() > 0) e = expQ.pop_front();
		check(seen, e);
	endtask

	// watch the answer pulses, settled at the falling edge
	initial forever begin
		@(negedge ref_clk);
		if (nrst === 1'b1) begin
			if (dataValid === 1'b1) take({3'h0, wordAccess, dataAddr});
			if (regValid === 1'b1) take({4'h2, 4'h0, regValue});
			if (pcLoad === 1'b1) take({4'h4, pcValue});
			if (tblReq === 1'b1) take({4'h6, tblAddr});
			if (addrError === 1'b1) take({3'h4, 21'h0});
		end
	end

	// present one request when idle, called and left at a falling edge
	task issue(input cag_req_type q);
		int n;
		n = 0;
		while (reqReady !== 1'b1 && n < 20) begin
			reqValid = 1'b0;
			@(negedge ref_clk);
			n++;
		end
		if (n == 20) n_errors++;
		reqValid = 1'b1;
		req = q;
		expQ.push_back(expOf(q, regs));
		@(negedge ref_clk);
	endtask

	// table call; a held request during the wait must be ignored
	task tbl_call(input cag_req_type q, input int dly);
		logic [15:0] word;
		int n;
		word = 16'($urandom());
		issue(q);
		check({23'h0, reqReady}, 24'h0);
		expQ.push_back({8'h40, word});
		req.mode = MODE_DIRECT;
		repeat (dly) @(negedge ref_clk);
		tblRdValid = 1'b1;
		tblRdData = word;
		@(negedge ref_clk);
		tblRdValid = 1'b0;
		tblRdData = ~word;
		n = 0;
		while (reqReady !== 1'b1 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 20) n_errors++;
		reqValid = 1'b0;
		@(negedge ref_clk);
	endtask

	task end_of_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// watchdog, far beyond the expected run of some 530 cycles
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end

	// main sequence
	initial begin
		nrst = 1'b0;
		reqValid = 1'b0;
		req = '0;
		regs = '0;
		tblRdValid = 1'b0;
		tblRdData = 16'h0;
		n_errors = 0;
		n_compared = 0;
		void'($urandom(6));
		repeat (20) @(negedge ref_clk);
		check({23'h0, reqReady}, 24'h0);
		nrst = 1'b1;
		@(negedge ref_clk);
		check({23'h0, reqReady}, 24'h1);
		regs = 88'({$urandom(), $urandom(), $urandom()});
		// boundaries of the short direct and special register windows
		foreach (edges[i]) for (int k = 0; k < 4; k++) begin
			r = 36'({$urandom(), $urandom()});
			r.mode = k[1] ? MODE_SFR : MODE_SHORT;
			r.wordOp = k[0];
			r.imm8 = edges[i];
			issue(r);
		end
		// every mode first, then random back-to-back traffic
		for (int i = 0; i < 400; i++) begin
			regs = 88'({$urandom(), $urandom(), $urandom()});
			r = 36'({$urandom(), $urandom()});
			if (i < 16) r.mode = cag_mode_type'(i[3:0]);
			if (r.mode == MODE_TBL_CALL) tbl_call(r, $urandom_range(0, 3));
			else issue(r);
		end
		reqValid = 1'b0;
		repeat (3) @(negedge ref_clk);
		check(24'(expQ.size()), 24'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
